// ---- src/buzzer_melody_ctrl.sv ----
`timescale 1ns/1ps
module buzzer_melody_ctrl #(
    parameter int STEP_CYCLES = buzzer_pkg::STEP_UNIT_CYCLES
) (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic srst_in,
    // Register port
    input wire buzzer_pkg::bus_req_t bus_in,
    output logic [7:0] rdata_out,
    // Buzzer side
    output logic buzzer_pin_out,
    output logic supply_window_out,
    // Interrupt
    output logic irq_out
);

    localparam int MS_W = $clog2(STEP_CYCLES + 1);

    if (STEP_CYCLES < 2) begin : g_chk
        $error("buzzer_melody_ctrl: STEP_CYCLES too small");
    end

    function automatic logic wr_hit(input buzzer_pkg::bus_req_t b, input logic [15:0] a);
        return b.wr && b.addr == a;
    endfunction

    logic [11:0] div_a, div_b;
    logic [7:0] len_a, len_b, gap_a, gap_b, pow_count, seq_cnt, pow_cnt, wd;
    logic [2:0] irq_status, irq_mask, irq_events, sub_cnt;
    logic [1:0] step_sel;
    logic [MS_W-1:0] ms_cnt;
    buzzer_pkg::seq_state_t state;
    logic enable, polarity, ien_a, ien_b, flag_a, flag_b, go_a, go_b, base_sel, pow_ien, pow_flag, ping_pong;
    logic cur_b, pow_run, ms_tick, step_tick, wave, cfg_wr, en_eff, start_a, start_b, note_done, pow_expire;

    assign wd = bus_in.wdata;
    assign cfg_wr = wr_hit(bus_in, buzzer_pkg::BUZZER_CONFIG_ADDR);
    // Enable written in the same cycle as a go bit counts at once
    assign en_eff = cfg_wr ? wd[buzzer_pkg::CFG_ENABLE_BIT] : enable;
    assign start_a = cfg_wr && wd[buzzer_pkg::CFG_GO_A_BIT] && en_eff;
    assign start_b = cfg_wr && wd[buzzer_pkg::CFG_GO_B_BIT] && en_eff;
    assign note_done = state == buzzer_pkg::ST_GAP && seq_cnt == 8'h00;
    assign pow_expire = pow_run && pow_cnt == 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Plain storage registers
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            div_a <= 12'h000;
            div_b <= 12'h000;
            len_a <= buzzer_pkg::REG_RESET;
            len_b <= buzzer_pkg::REG_RESET;
            gap_a <= buzzer_pkg::REG_RESET;
            gap_b <= buzzer_pkg::REG_RESET;
            pow_count <= buzzer_pkg::REG_RESET;
            enable <= 1'b0;
            polarity <= 1'b0;
            ien_a <= 1'b0;
            ien_b <= 1'b0;
            step_sel <= 2'h0;
            base_sel <= 1'b0;
            pow_ien <= 1'b0;
            irq_mask <= 3'h0;
            ping_pong <= 1'b0;
        end else begin
            if (wr_hit(bus_in, buzzer_pkg::NOTE_A_DIV_LO_ADDR)) div_a[7:0] <= wd;
            if (wr_hit(bus_in, buzzer_pkg::NOTE_A_DIV_HI_ADDR)) div_a[11:8] <= wd[3:0];
            if (wr_hit(bus_in, buzzer_pkg::NOTE_A_LENGTH_ADDR)) len_a <= wd;
            if (wr_hit(bus_in, buzzer_pkg::NOTE_A_GAP_ADDR)) gap_a <= wd;
            if (wr_hit(bus_in, buzzer_pkg::NOTE_B_DIV_LO_ADDR)) div_b[7:0] <= wd;
            if (wr_hit(bus_in, buzzer_pkg::NOTE_B_DIV_HI_ADDR)) div_b[11:8] <= wd[3:0];
            if (wr_hit(bus_in, buzzer_pkg::NOTE_B_LENGTH_ADDR)) len_b <= wd;
            if (wr_hit(bus_in, buzzer_pkg::NOTE_B_GAP_ADDR)) gap_b <= wd;
            if (wr_hit(bus_in, buzzer_pkg::SUPPLY_WINDOW_ADDR)) pow_count <= wd;
            if (cfg_wr) begin
                enable <= wd[buzzer_pkg::CFG_ENABLE_BIT];
                polarity <= wd[buzzer_pkg::CFG_POLARITY_BIT];
                ien_b <= wd[buzzer_pkg::CFG_IEN_B_BIT];
                ien_a <= wd[buzzer_pkg::CFG_IEN_A_BIT];
            end
            if (wr_hit(bus_in, buzzer_pkg::TIME_STEP_ADDR)) begin
                step_sel <= wd[buzzer_pkg::TS_SEL_LSB +: 2];
                base_sel <= wd[buzzer_pkg::TS_BASE_BIT];
                pow_ien <= wd[buzzer_pkg::TS_IEN_BIT];
            end
            if (wr_hit(bus_in, buzzer_pkg::IRQ_MASK_ADDR)) irq_mask <= wd[2:0];
            if (wr_hit(bus_in, buzzer_pkg::MELODY_MODE_ADDR)) ping_pong <= wd[buzzer_pkg::MODE_PINGPONG_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Time step: millisecond ticks, then a 1/2/4/8 divider
    always_ff @(posedge ref_clk_in) begin
        if (srst_in || !enable) begin
            ms_cnt <= '0;
            sub_cnt <= 3'h0;
        end else if (ms_tick) begin
            ms_cnt <= '0;
            sub_cnt <= sub_cnt + 1'b1;
        end else begin
            ms_cnt <= ms_cnt + 1'b1;
        end
    end

    assign ms_tick = ms_cnt == MS_W'(STEP_CYCLES - 1);
    // Free running, so the first step of a note may be short by up to one step
    assign step_tick = ms_tick && ((sub_cnt & ((3'h1 << step_sel) - 3'h1)) == ((3'h1 << step_sel) - 3'h1));

    ////////////////////////////////////////////////////////////////////////////
    // Go bits; set beats the self clear
    always_ff @(posedge ref_clk_in) begin
        if (srst_in || !en_eff) begin
            go_a <= 1'b0;
            go_b <= 1'b0;
        end else begin
            if (start_a || (note_done && cur_b && ping_pong)) begin
                go_a <= 1'b1;
            end else if (note_done && !cur_b) begin
                go_a <= 1'b0;
            end
            if (start_b || (note_done && !cur_b && ping_pong)) begin
                go_b <= 1'b1;
            end else if (note_done && cur_b) begin
                go_b <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Note sequencer
    always_ff @(posedge ref_clk_in) begin
        if (srst_in || !enable) begin
            state <= buzzer_pkg::ST_IDLE;
            cur_b <= 1'b0;
            seq_cnt <= 8'h00;
        end else begin
            unique case (state)
                buzzer_pkg::ST_IDLE: begin
                    if (go_a) begin
                        cur_b <= 1'b0;
                        seq_cnt <= len_a;
                        state <= buzzer_pkg::ST_TONE;
                    end else if (go_b) begin
                        cur_b <= 1'b1;
                        seq_cnt <= len_b;
                        state <= buzzer_pkg::ST_TONE;
                    end
                end
                buzzer_pkg::ST_TONE: begin
                    if (seq_cnt == 8'h00) begin
                        seq_cnt <= cur_b ? gap_b : gap_a;
                        state <= buzzer_pkg::ST_GAP;
                    end else if (step_tick) begin
                        seq_cnt <= seq_cnt - 1'b1;
                    end
                end
                buzzer_pkg::ST_GAP: begin
                    if (seq_cnt == 8'h00) begin
                        state <= buzzer_pkg::ST_IDLE;
                    end else if (step_tick) begin
                        seq_cnt <= seq_cnt - 1'b1;
                    end
                end
            endcase
        end
    end

    tone_wave #(.DIV_W(12)) u_tone (
        .ref_clk_in(ref_clk_in),
        .srst_in(srst_in),
        .run_in(enable && state == buzzer_pkg::ST_TONE),
        .base_sel_in(base_sel),
        .divider_in(cur_b ? div_b : div_a),
        .wave_out(wave)
    );

    // Idle wave is 0, so the pin rests at the polarity level
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            buzzer_pin_out <= 1'b0;
        end else begin
            buzzer_pin_out <= (wave && enable && state == buzzer_pkg::ST_TONE) ^ polarity;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Supply-window timer, also drives the external supply switch
    always_ff @(posedge ref_clk_in) begin
        if (srst_in || !en_eff) begin
            pow_run <= 1'b0;
            pow_cnt <= 8'h00;
        end else if (start_a || start_b) begin
            pow_run <= 1'b1;
            pow_cnt <= pow_count;
        end else if (pow_expire) begin
            pow_run <= 1'b0;
        end else if (pow_run && step_tick) begin
            pow_cnt <= pow_cnt - 1'b1;
        end
    end

    assign supply_window_out = pow_run;

    ////////////////////////////////////////////////////////////////////////////
    // Sticky flags: hardware set wins over a software clear
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            flag_a <= 1'b0;
            flag_b <= 1'b0;
            pow_flag <= 1'b0;
        end else begin
            if (note_done && !cur_b && ien_a) begin
                flag_a <= 1'b1;
            end else if (cfg_wr && !wd[buzzer_pkg::CFG_FLAG_A_BIT]) begin
                flag_a <= 1'b0;
            end
            if (note_done && cur_b && ien_b) begin
                flag_b <= 1'b1;
            end else if (cfg_wr && !wd[buzzer_pkg::CFG_FLAG_B_BIT]) begin
                flag_b <= 1'b0;
            end
            if (pow_expire) begin
                pow_flag <= 1'b1;
            end else if (wr_hit(bus_in, buzzer_pkg::TIME_STEP_ADDR) && !wd[buzzer_pkg::TS_FLAG_BIT]) begin
                pow_flag <= 1'b0;
            end
        end
    end

    assign irq_events = {pow_expire, note_done && cur_b && ien_b, note_done && !cur_b && ien_a};

    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            irq_status <= 3'h0;
        end else if (wr_hit(bus_in, buzzer_pkg::IRQ_STATUS_ADDR)) begin
            irq_status <= (irq_status & ~wd[2:0]) | irq_events;
        end else begin
            irq_status <= irq_status | irq_events;
        end
    end

    // Supply-window source passes only with its own enable
    assign irq_out = |(irq_status & irq_mask & {pow_ien, 2'b11});

    ////////////////////////////////////////////////////////////////////////////
    // Read port
    always_ff @(posedge ref_clk_in) begin
        if (srst_in || !bus_in.rd) begin
            rdata_out <= 8'h00;
        end else begin
            case (bus_in.addr)
                buzzer_pkg::NOTE_A_DIV_LO_ADDR: rdata_out <= div_a[7:0];
                buzzer_pkg::NOTE_A_DIV_HI_ADDR: rdata_out <= {4'h0, div_a[11:8]};
                buzzer_pkg::NOTE_A_LENGTH_ADDR: rdata_out <= len_a;
                buzzer_pkg::NOTE_A_GAP_ADDR: rdata_out <= gap_a;
                buzzer_pkg::NOTE_B_DIV_LO_ADDR: rdata_out <= div_b[7:0];
                buzzer_pkg::NOTE_B_DIV_HI_ADDR: rdata_out <= {4'h0, div_b[11:8]};
                buzzer_pkg::NOTE_B_LENGTH_ADDR: rdata_out <= len_b;
                buzzer_pkg::NOTE_B_GAP_ADDR: rdata_out <= gap_b;
                buzzer_pkg::BUZZER_CONFIG_ADDR: begin
                    rdata_out <= {enable, polarity, ien_b, ien_a, flag_b, flag_a,
                                  state != buzzer_pkg::ST_IDLE && cur_b,
                                  state != buzzer_pkg::ST_IDLE && !cur_b};
                end
                buzzer_pkg::SUPPLY_WINDOW_ADDR: rdata_out <= pow_count;
                buzzer_pkg::TIME_STEP_ADDR: rdata_out <= {step_sel, 1'b0, base_sel, 2'h0, pow_ien, pow_flag};
                buzzer_pkg::IRQ_STATUS_ADDR: rdata_out <= {5'h00, irq_status};
                buzzer_pkg::IRQ_MASK_ADDR: rdata_out <= {5'h00, irq_mask};
                buzzer_pkg::MELODY_MODE_ADDR: rdata_out <= {7'h00, ping_pong};
                default: rdata_out <= 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    property p_pow_start;
        @(posedge ref_clk_in) disable iff (srst_in)
        (start_a || start_b) |=> pow_run && pow_cnt == $past(pow_count);
    endproperty
    a_pow_start: assert property (p_pow_start) else $error("supply window did not start");
    property p_step_unit;
        @(posedge ref_clk_in) disable iff (srst_in)
        step_sel == 2'h0 |-> step_tick == ms_tick;
    endproperty
    a_step_unit: assert property (p_step_unit) else $error("1 ms step mismatch");
    property p_pow_flag;
        @(posedge ref_clk_in) disable iff (srst_in)
        pow_expire |=> pow_flag && !pow_run;
    endproperty
    a_pow_flag: assert property (p_pow_flag) else $error("supply window flag not set");
    property p_disabled_idle;
        @(posedge ref_clk_in) disable iff (srst_in)
        !enable |=> state == buzzer_pkg::ST_IDLE;
    endproperty
    a_disabled_idle: assert property (p_disabled_idle) else $error("sequencer ran while disabled");
    // Registered pin follows a polarity write one cycle late
    property p_pin_idle;
        @(posedge ref_clk_in) disable iff (srst_in)
        (state != buzzer_pkg::ST_TONE) ##1 (state != buzzer_pkg::ST_TONE) |-> buzzer_pin_out == $past(polarity);
    endproperty
    a_pin_idle: assert property (p_pin_idle) else $error("pin active while idle");
    property p_flag_b;
        @(posedge ref_clk_in) disable iff (srst_in)
        note_done && cur_b && ien_b |=> flag_b;
    endproperty
    a_flag_b: assert property (p_flag_b) else $error("note B end flag missed");
    property p_flag_a;
        @(posedge ref_clk_in) disable iff (srst_in)
        note_done && !cur_b && ien_a |=> flag_a;
    endproperty
    a_flag_a: assert property (p_flag_a) else $error("note A end flag missed");
    sequence s_b_finish;
        note_done && cur_b && enable && !ping_pong && !bus_in.wr;
    endsequence
    property p_go_b_clear;
        @(posedge ref_clk_in) disable iff (srst_in)
        s_b_finish |=> !go_b ##1 state == buzzer_pkg::ST_IDLE || go_a;
    endproperty
    a_go_b_clear: assert property (p_go_b_clear) else $error("note B go did not clear");
    sequence s_both_armed;
        state == buzzer_pkg::ST_IDLE && go_a && go_b && enable && !bus_in.wr;
    endsequence
    property p_a_first;
        @(posedge ref_clk_in) disable iff (srst_in)
        s_both_armed |=> state == buzzer_pkg::ST_TONE && !cur_b;
    endproperty
    a_a_first: assert property (p_a_first) else $error("note A not played first");
    property p_tone_to_gap;
        @(posedge ref_clk_in) disable iff (srst_in)
        state == buzzer_pkg::ST_TONE && seq_cnt == 8'h00 && enable && !cfg_wr |=> state == buzzer_pkg::ST_GAP;
    endproperty
    a_tone_to_gap: assert property (p_tone_to_gap) else $error("tone did not end into gap");

endmodule

// ---- src/buzzer_pkg.sv ----
package buzzer_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register offsets
    localparam logic [15:0] NOTE_A_DIV_LO_ADDR = 16'ha040;
    localparam logic [15:0] NOTE_A_DIV_HI_ADDR = 16'ha041;
    localparam logic [15:0] NOTE_A_LENGTH_ADDR = 16'ha042;
    localparam logic [15:0] NOTE_A_GAP_ADDR = 16'ha043;
    localparam logic [15:0] NOTE_B_DIV_LO_ADDR = 16'ha044;
    localparam logic [15:0] NOTE_B_DIV_HI_ADDR = 16'ha045;
    localparam logic [15:0] NOTE_B_LENGTH_ADDR = 16'ha046;
    localparam logic [15:0] NOTE_B_GAP_ADDR = 16'ha047;
    localparam logic [15:0] BUZZER_CONFIG_ADDR = 16'ha048;
    localparam logic [15:0] SUPPLY_WINDOW_ADDR = 16'ha049;
    localparam logic [15:0] TIME_STEP_ADDR = 16'ha04a;
    localparam logic [15:0] IRQ_STATUS_ADDR = 16'ha04b;
    localparam logic [15:0] IRQ_MASK_ADDR = 16'ha04c;
    localparam logic [15:0] MELODY_MODE_ADDR = 16'ha04d;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int CFG_ENABLE_BIT = 7;
    localparam int CFG_POLARITY_BIT = 6;
    localparam int CFG_IEN_B_BIT = 5;
    localparam int CFG_IEN_A_BIT = 4;
    localparam int CFG_FLAG_B_BIT = 3;
    localparam int CFG_FLAG_A_BIT = 2;
    localparam int CFG_GO_B_BIT = 1;
    localparam int CFG_GO_A_BIT = 0;
    localparam int TS_SEL_LSB = 6;
    localparam int TS_BASE_BIT = 4;
    localparam int TS_IEN_BIT = 1;
    localparam int TS_FLAG_BIT = 0;
    localparam int IRQ_A_BIT = 0;
    localparam int IRQ_B_BIT = 1;
    localparam int IRQ_POW_BIT = 2;
    localparam int MODE_PINGPONG_BIT = 0;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values and timing
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam int CLK_PERIOD_NS = 5;
    localparam int STEP_UNIT_NS = 1000000;
    localparam int STEP_UNIT_CYCLES = STEP_UNIT_NS / CLK_PERIOD_NS;
    localparam int TONE_BASE_DIV_LOW = 32;
    localparam int TONE_BASE_DIV_HIGH = 64;

    ////////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [1:0] {ST_IDLE, ST_TONE, ST_GAP} seq_state_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } bus_req_t;

endpackage

// ---- src/tone_wave.sv ----
`timescale 1ns/1ps
module tone_wave #(
    parameter int DIV_W = 12
) (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic srst_in,
    // Control
    input wire logic run_in,
    input wire logic base_sel_in,
    input wire logic [DIV_W-1:0] divider_in,
    // Square wave
    output logic wave_out
);

    localparam int PRE_W = $clog2(buzzer_pkg::TONE_BASE_DIV_HIGH);
    // Half periods, since the wave toggles twice per tone period
    localparam logic [PRE_W-1:0] PRE_LOW_END = PRE_W'(buzzer_pkg::TONE_BASE_DIV_LOW / 2 - 1);
    localparam logic [PRE_W-1:0] PRE_HIGH_END = PRE_W'(buzzer_pkg::TONE_BASE_DIV_HIGH / 2 - 1);

    if (DIV_W < 1 || DIV_W > 16) begin : g_chk
        $error("tone_wave: DIV_W out of range");
    end

    logic [PRE_W-1:0] pre_cnt;
    logic [DIV_W-1:0] div_cnt;
    logic pre_end;

    // Compare with >= so a base change mid-tone cannot run the prescaler past its end
    assign pre_end = pre_cnt >= (base_sel_in ? PRE_HIGH_END : PRE_LOW_END);

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge ref_clk_in) begin
        if (srst_in || !run_in) begin
            pre_cnt <= '0;
            div_cnt <= '0;
            wave_out <= 1'b0;
        end else if (pre_end) begin
            pre_cnt <= '0;
            if (div_cnt == divider_in) begin
                div_cnt <= '0;
                wave_out <= !wave_out;
            end else begin
                div_cnt <= div_cnt + 1'b1;
            end
        end else begin
            pre_cnt <= pre_cnt + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    property p_pre_bound;
        @(posedge ref_clk_in) disable iff (srst_in)
        pre_cnt <= (base_sel_in ? PRE_HIGH_END : PRE_LOW_END) || $changed(base_sel_in);
    endproperty
    a_pre_bound: assert property (p_pre_bound) else $error("tone prescaler overran its base");

endmodule

// ---- test/buzzer_load.sv ----
`timescale 1ns/1ps
module buzzer_load (
    // Clock
    input wire logic ref_clk_in,
    // Drive from the controller
    input wire logic buzzer_pin_in,
    input wire logic supply_window_in,
    // Seen tone timing
    output int half_period_out
);
    // Element only sounds while its supply switch is closed
    int since = 0;
    logic last = 1'b0;
    always_ff @(posedge ref_clk_in) begin
        last <= buzzer_pin_in;
        since <= since + 1;
        if (last !== buzzer_pin_in && supply_window_in === 1'b1) begin
            half_period_out <= since;
            since <= 1;
        end
    end
endmodule

// ---- test/buzzer_melody_note_control_test.sv ----
`timescale 1ns/1ps
module buzzer_melody_note_control_test;
    // Short step keeps the run brief
    localparam int STEP = 20;
    localparam logic [15:0] CFG = 16'ha048;
    logic ref_clk_in = 1'b0;
    logic srst_in = 1'b1;
    buzzer_pkg::bus_req_t bus = '0;
    logic [7:0] rdata_out;
    logic buzzer_pin_out;
    logic supply_window_out;
    logic irq_out;
    int half_period;
    int miscompares = 0;
    int samples_checked = 0;
    integer seed = 62;
    logic [7:0] d;
    logic [7:0] v;
    int n;
    int hp;

    buzzer_melody_ctrl #(.STEP_CYCLES(STEP)) buzzer_melody_ctrl_i (.ref_clk_in(ref_clk_in), .srst_in(srst_in),
        .bus_in(bus), .rdata_out(rdata_out), .buzzer_pin_out(buzzer_pin_out),
        .supply_window_out(supply_window_out), .irq_out(irq_out));
    buzzer_load buzzer_load_i (.ref_clk_in(ref_clk_in), .buzzer_pin_in(buzzer_pin_out),
        .supply_window_in(supply_window_out), .half_period_out(half_period));

    initial begin
        forever #2.5 ref_clk_in = ~ref_clk_in;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] w);
        @(posedge ref_clk_in);
        bus.addr <= a;
        bus.wdata <= w;
        bus.wr <= 1'b1;
        @(posedge ref_clk_in);
        bus.wr <= 1'b0;
    endtask

    // Data stands only in the cycle after the strobe
    task automatic rd(input logic [15:0] a);
        @(posedge ref_clk_in);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge ref_clk_in);
        bus.rd <= 1'b0;
        #1 d = rdata_out;
    endtask

    task automatic wait_bits(input logic [1:0] want);
        n = 0;
        do begin
            rd(CFG);
            n++;
        end while (d[1:0] !== want && n < 1000);
        chk("busy bits", want, d[1:0]);
    endtask

    task automatic give_verdict();
        $display("Counts: %0d checked, %0d mismatches", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #200000;
        miscompares++;
        $display("Watchdog expired");
        give_verdict();
    end

    initial begin
        repeat (6) @(posedge ref_clk_in);
        srst_in <= 1'b0;
        for (int a = 16'ha040; a <= 16'ha050; a++) begin
            rd(a[15:0]);
            chk("reset value", 8'h00, d);
        end
        for (int a = 16'ha040; a <= 16'ha049; a++) begin
            v = $random(seed);
            // Keep the controller disabled so no note starts here
            if (a == CFG) v = v & 8'h7f;
            wr(a[15:0], v);
            rd(a[15:0]);
            chk("read back", v & ((a == 16'ha041 || a == 16'ha045) ? 8'h0f : (a == CFG) ? 8'h70 : 8'hff), d);
        end
        $display("Test registers done");
        wr(16'ha049, 8'hff);
        for (int b = 0; b < 2; b++) begin
            v = $random(seed) & 1;
            hp = 16 * (v + 1) * (b + 1);
            wr(16'ha040, v);
            wr(16'ha041, 8'h00);
            wr(16'ha042, 8'h0c);
            wr(16'ha043, 8'h02);
            wr(16'ha04a, {3'b000, b[0], 4'h0});
            wr(CFG, 8'h91);
            rd(CFG);
            chk("busy a", 1'b1, d[0]);
            repeat (2 * hp + 10) @(posedge ref_clk_in);
            chk("half period", hp, half_period);
            wait_bits(2'b00);
            chk("flag a", 1'b1, d[2]);
            chk("irq masked", 1'b0, irq_out);
            wr(16'ha04c, 8'h01);
            #1 chk("irq set", 1'b1, irq_out);
            wr(16'ha04b, 8'h01);
            #1 chk("irq cleared", 1'b0, irq_out);
            wr(16'ha04c, 8'h00);
        end
        $display("Test tone done");
        wr(16'ha046, 8'h04);
        wr(16'ha047, 8'h03);
        wr(CFG, 8'hb3);
        rd(CFG);
        chk("a first", 2'b01, d[1:0]);
        wait_bits(2'b10);
        wait_bits(2'b00);
        chk("both flags", 2'b11, d[3:2]);
        wr(CFG, 8'h80);
        rd(CFG);
        chk("flags cleared", 8'h80, d);
        wr(16'ha04d, 8'h01);
        wr(CFG, 8'h81);
        wait_bits(2'b10);
        wait_bits(2'b01);
        wr(16'ha04d, 8'h00);
        wait_bits(2'b00);
        $display("Test sequence done");
        wr(CFG, 8'h40);
        repeat (2) @(posedge ref_clk_in);
        #1 chk("idle pin", 1'b1, buzzer_pin_out);
        wr(CFG, 8'hc1);
        repeat (60) @(posedge ref_clk_in);
        wr(CFG, 8'h40);
        repeat (2) @(posedge ref_clk_in);
        #1 chk("disabled pin", 1'b1, buzzer_pin_out);
        chk("supply off", 1'b0, supply_window_out);
        rd(CFG);
        chk("go dropped", 2'b00, d[1:0]);
        $display("Test polarity done");
        wr(16'ha042, 8'h00);
        wr(16'ha049, 8'h02);
        wr(16'ha04c, 8'h04);
        for (int s = 0; s < 4; s++) begin
            wr(16'ha04a, {s[1:0], 6'h02});
            wr(CFG, 8'h81);
            #1 n = 0;
            while (supply_window_out === 1'b1 && n < 400) begin
                @(posedge ref_clk_in);
                #1 n++;
            end
            chk("window span", 1'b1, n >= (STEP << s) - 2 && n <= (2 * STEP << s) + 4);
            rd(16'ha04a);
            chk("window flag", 1'b1, d[0]);
            chk("window irq", 1'b1, irq_out);
            wr(16'ha04a, {s[1:0], 6'h02});
            wr(16'ha04b, 8'h04);
            #1 chk("window irq off", 1'b0, irq_out);
        end
        $display("Test supply window done");
        give_verdict();
    end
endmodule
